// >>> rtl/sar_seq_ctrl.sv
// Sequencer, power and parallel result control of the converter
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sar_seq_cfg.svh"
module sar_seq_ctrl
	import sar_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic conversion_start_n_i,
	input wire logic conversion_clock_in_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic word_byte_i,
	input wire logic high_byte_en_i,
	input wire logic [11:0] sample_data_i,
	output logic [11:0] data_o,
	output logic data_oe_o,
	output logic busy_o,
	output logic track_o,
	output logic ref_internal_o,
	output logic power_down_o,
	output logic [2:0] mux_channel_o
);

	typedef struct packed {
		logic [`PIN_CNT-1:0] s1;
		logic [`PIN_CNT-1:0] s2;
		logic [`PIN_CNT-1:0] s3;
		logic [`PIN_CNT-1:0] lvl;
		logic start_fall;
		logic start_rise;
		logic cclk_rise;
		logic cclk_fall;
		logic ack;
		logic [31:0] rdat;
		logic [7:0] ctrl;
		logic [7:0] shadow;
		seq_mode_t mode;
		logic [2:0] last_ch;
		logic [2:0] next_ch;
		logic [2:0] conv_ch;
		logic busy;
		logic track;
		logic init_done;
		logic pdown;
		logic [4:0] acq_cnt;
		logic acq_ok;
		logic [`RES_W-1:0] res;
		logic [2:0] res_ch;
		logic [11:0] data;
		logic oe;
		logic [2:0] mux;
	} ctrl_state_t;

	localparam logic [4:0] ACQ_CNT = 5'(`ACQ_CYCLES);

	ctrl_state_t q;
	ctrl_state_t d;
	conv_if cv ();

	logic [`PIN_CNT-1:0] pins;
	logic req;
	logic wr_fire;
	logic rd_take;
	logic [31:0] rd_mux;
	logic [2:0] wr_addr;
	logic wr_seq;
	logic wr_shadow_enable_bit;
	power_mode_t pm;
	logic auto_pm;

	// Next enabled shadow channel above cur, wrapping around
	function automatic logic [2:0] next_set(
		input logic [7:0] mask,
		input logic [2:0] cur
	);
		logic [2:0] ch;
		logic found;
		next_set = cur;
		found = 1'b0;
		for (int i = 1; i <= 8; i++)
		begin
			ch = cur + 3'(i);
			if (!found && mask[ch])
			begin
				next_set = ch;
				found = 1'b1;
			end
		end
	endfunction : next_set

	conv_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cv(cv.timer)
	);

	// Pin bank in index order
	assign pins = {high_byte_en_i, word_byte_i, rd_n_i, cs_n_i,
		conversion_clock_in_i, conversion_start_n_i};

	// Bus decode: a write lands on the edge where the master sees ack
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_fire = req & q.ack & wb_we_i & wb_sel_i[0];
	assign rd_take = req & ~q.ack;
	assign wr_addr = wb_dat_i[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
	assign wr_seq = wb_dat_i[`CTRL_SEQ_BIT];
	assign wr_shadow_enable_bit = wb_dat_i[`CTRL_SHADOW_ENABLE_BIT_BIT];
	assign pm = power_mode_t'(q.ctrl[`CTRL_PM_MSB:`CTRL_PM_LSB]);
	assign auto_pm = (pm == PM_AUTO_SHUTDOWN) || (pm == PM_AUTO_STANDBY);

	// Read mux; unmapped offsets answer with zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			`OFS_CTRL: rd_mux[7:0] = q.ctrl;
			`OFS_SHADOW: rd_mux[7:0] = q.shadow;
			`OFS_STATUS:
			begin
				rd_mux[`ST_BUSY] = q.busy;
				rd_mux[`ST_TRACK] = q.track;
				rd_mux[`ST_PDOWN] = q.pdown;
				rd_mux[`ST_ACQ_OK] = q.acq_ok;
				rd_mux[`ST_NEXT_LSB +: 3] = q.next_ch;
				rd_mux[`ST_CONV_LSB +: 3] = q.conv_ch;
				rd_mux[`ST_INIT] = q.init_done;
			end
			`OFS_RESULT:
			begin
				rd_mux[`RES_W-1:0] = q.res;
				rd_mux[`RES_CH_LSB +: 3] = q.res_ch;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Next state of the whole block
	always_comb
	begin
		d = q;
		// Three-stage pin sync; level moves once stages two and three agree
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < `PIN_CNT; i++)
		begin
			if (q.s2[i] == q.s3[i])
				d.lvl[i] = q.s3[i];
		end
		d.start_fall = q.lvl[`PIN_START] & ~d.lvl[`PIN_START];
		d.start_rise = ~q.lvl[`PIN_START] & d.lvl[`PIN_START];
		d.cclk_rise = ~q.lvl[`PIN_CCLK] & d.lvl[`PIN_CCLK];
		d.cclk_fall = q.lvl[`PIN_CCLK] & ~d.lvl[`PIN_CCLK];
		// Starts before power-up init or during a conversion are dropped
		if (!q.init_done || q.busy)
			d.start_fall = 1'b0;

		// Single-cycle ack, dropped the cycle after it is given
		d.ack = rd_take;
		if (rd_take)
			d.rdat = rd_mux;

		// Control write reprograms the sequencer
		if (wr_fire && wb_adr_i == `OFS_SHADOW)
			d.shadow = wb_dat_i[7:0];
		if (wr_fire && wb_adr_i == `OFS_CTRL)
		begin
			d.ctrl = wb_dat_i[7:0];
			if (wr_seq && wr_shadow_enable_bit)
			begin
				d.mode = SEQ_CONSEC;
				d.last_ch = wr_addr;
				d.next_ch = 3'h0;
			end
			else if (!wr_seq && !wr_shadow_enable_bit)
			begin
				d.mode = SEQ_SINGLE;
				d.next_ch = wr_addr;
			end
			else if (!wr_seq && wr_shadow_enable_bit)
			begin
				d.mode = SEQ_SHADOW;
				d.next_ch = next_set(q.shadow, 3'h7);
			end
			// Sequence 1, shadow 0 leaves the running sequence alone
		end

		// Conversion start: latch channel, step the sequencer
		if (q.start_fall)
		begin
			d.busy = 1'b1;
			d.conv_ch = q.next_ch;
			case (q.mode)
				SEQ_CONSEC:
				begin
					// Shadow mask not consulted in this mode
					if (q.next_ch == q.last_ch)
						d.next_ch = 3'h0;
					else
						d.next_ch = q.next_ch + 3'h1;
				end
				SEQ_SHADOW: d.next_ch = next_set(q.shadow, q.next_ch);
				SEQ_SINGLE: d.next_ch = q.next_ch;
				default: d.next_ch = q.next_ch;
			endcase
		end

		// End of conversion or abort
		if (cv.done)
		begin
			d.busy = 1'b0;
			d.res = sample_data_i;
			d.res_ch = q.conv_ch;
			if (auto_pm)
				d.pdown = 1'b1;
		end
		if (cv.abort)
			d.busy = 1'b0;

		// Rising start: power-up init and wake from auto modes
		if (q.start_rise)
		begin
			d.init_done = 1'b1;
			// A done in the same cycle wins, so the block still sleeps
			if (!cv.done)
				d.pdown = 1'b0;
		end
		if (pm == PM_FULL_OFF)
			d.pdown = 1'b1;
		else if (!auto_pm && !cv.done)
			d.pdown = 1'b0;

		// Track only after init and while the timer is not holding
		d.track = d.init_done & ~cv.hold;
		if (!q.track)
			d.acq_cnt = 5'h00;
		else if (q.acq_cnt != ACQ_CNT)
			d.acq_cnt = q.acq_cnt + 5'h01;
		d.acq_ok = (q.acq_cnt == ACQ_CNT);

		// Parallel result bus, word or byte mode
		if (q.lvl[`PIN_WB])
			d.data = q.res;
		else if (q.lvl[`PIN_HBEN])
			d.data = {4'h0, {(`BYTE_W - (`RES_W - `BYTE_W)){1'b0}},
				q.res[`RES_W-1:`BYTE_W]};
		else
			d.data = {4'h0, q.res[`BYTE_W-1:0]};
		d.oe = ~q.lvl[`PIN_CS] & ~q.lvl[`PIN_RD];
		// Channel on the mux: converting one while busy, else the next
		d.mux = d.busy ? d.conv_ch : d.next_ch;
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q.s1 <= `PIN_RST;
			q.s2 <= `PIN_RST;
			q.s3 <= `PIN_RST;
			q.lvl <= `PIN_RST;
			q.start_fall <= 1'b0;
			q.start_rise <= 1'b0;
			q.cclk_rise <= 1'b0;
			q.cclk_fall <= 1'b0;
			q.ack <= 1'b0;
			q.rdat <= 32'h0000_0000;
			q.ctrl <= `CTRL_RST;
			q.shadow <= `SHADOW_RST;
			q.mode <= SEQ_SINGLE;
			q.last_ch <= 3'h0;
			q.next_ch <= 3'h0;
			q.conv_ch <= 3'h0;
			q.busy <= 1'b0;
			q.track <= 1'b0;
			q.init_done <= 1'b0;
			q.pdown <= 1'b0;
			q.acq_cnt <= 5'h00;
			q.acq_ok <= 1'b0;
			q.res <= 12'h000;
			q.res_ch <= 3'h0;
			q.data <= 12'h000;
			q.oe <= 1'b0;
			q.mux <= 3'h0;
		end
		else
			q <= d;
	end

	// Events to the timer, all registered pulses
	assign cv.start_fall = q.start_fall;
	assign cv.start_rise = q.start_rise;
	assign cv.cclk_rise = q.cclk_rise;
	assign cv.cclk_fall = q.cclk_fall;

	// Outputs straight from flip-flops
	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign busy_o = q.busy;
	assign track_o = q.track;
	assign ref_internal_o = q.ctrl[`CTRL_REF_BIT];
	assign power_down_o = q.pdown;
	assign mux_channel_o = q.mux;
	assign data_o = q.data;
	assign data_oe_o = q.oe;

endmodule : sar_seq_ctrl

// >>> pkg/sar_seq_cfg.svh
// Constants for the converter sequencer control block
// Function
// - Sequence and shadow bits both 1: convert channels 0 up to address field
// - Consecutive mode entered by writing 1 to sequence and shadow bits
// - Consecutive mode ignores the shadow channel mask entirely
// - After entering consecutive mode, start at channel 0, then step upward
// - After final channel wrap to 0 and repeat while no control write
// - Reference bit 1 selects on-chip reference, 0 selects external
// - Word/byte input high gives full word, low gives byte mode
// - Start falling edge begins conversion and puts track-and-hold into hold
// - Busy rises when start goes low and stays high for the conversion
// - Busy falls when the conversion completes
// - Start rising before 14th clock falling edge aborts and returns to track
// - Track-and-hold returns to tracking on 13th conversion clock rising edge
// - First start rising edge after power-up puts track-and-hold in track
// - Auto shutdown and auto standby modes power down after each conversion
// - In auto modes a start rising edge powers the device back up
// - Sequence and shadow both 0: each control write selects one channel
// - Sequence 0, shadow 1: cycle ascending through shadow-enabled channels
`ifndef SAR_SEQ_CFG_SVH
`define SAR_SEQ_CFG_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SHADOW 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESULT 8'h0c

// Control register fields
`define CTRL_ADDR_LSB 0
`define CTRL_ADDR_MSB 2
`define CTRL_SHADOW_ENABLE_BIT_BIT 3
`define CTRL_SEQ_BIT 4
`define CTRL_REF_BIT 5
`define CTRL_PM_LSB 6
`define CTRL_PM_MSB 7
`define CTRL_RST 8'h00
`define SHADOW_RST 8'h00

// Status register fields
`define ST_BUSY 0
`define ST_TRACK 1
`define ST_PDOWN 2
`define ST_ACQ_OK 3
`define ST_NEXT_LSB 4
`define ST_CONV_LSB 8
`define ST_INIT 11
`define RES_CH_LSB 12

// Pin indices in the synchroniser bank and their idle levels
`define PIN_START 0
`define PIN_CCLK 1
`define PIN_CS 2
`define PIN_RD 3
`define PIN_WB 4
`define PIN_HBEN 5
`define PIN_CNT 6
`define PIN_RST 6'h1d

// Conversion clock edge counts
`define HOLD_RELEASE_RISE 4'hd
`define CONV_DONE_FALL 4'he

// Acquisition timing
`define CLK_PERIOD_NS 5
`define ACQ_TIME_NS 125
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Result width
`define RES_W 12
`define BYTE_W 8

`endif

// >>> pkg/sar_seq_pkg.sv
// Types shared by the converter sequencer control block
package sar_seq_pkg;

	typedef enum logic [1:0] {
		PM_NORMAL,
		PM_FULL_OFF,
		PM_AUTO_SHUTDOWN,
		PM_AUTO_STANDBY
	} power_mode_t;

	typedef enum logic [1:0] {
		SEQ_SINGLE,
		SEQ_SHADOW,
		SEQ_CONSEC
	} seq_mode_t;

	typedef enum logic {
		T_IDLE,
		T_CONV
	} timer_state_t;

endpackage : sar_seq_pkg

// >>> pkg/conv_if.sv
// Event and status carrier between sequencer control and conversion timer
`timescale 1ns/1ps
interface conv_if;
	logic start_fall;
	logic start_rise;
	logic cclk_rise;
	logic cclk_fall;
	logic hold;
	logic done;
	logic abort;

	modport ctrl (
		output start_fall,
		output start_rise,
		output cclk_rise,
		output cclk_fall,
		input hold,
		input done,
		input abort
	);

	modport timer (
		input start_fall,
		input start_rise,
		input cclk_rise,
		input cclk_fall,
		output hold,
		output done,
		output abort
	);
endinterface : conv_if

// >>> rtl/conv_timer.sv
// Conversion timer counting conversion clock edges from the start strobe
`timescale 1ns/1ps
`include "sar_seq_cfg.svh"
module conv_timer
	import sar_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	conv_if.timer cv
);

	typedef struct packed {
		timer_state_t st;
		logic [3:0] rise_cnt;
		logic [3:0] fall_cnt;
		logic hold;
		logic done;
		logic abort;
	} tmr_state_t;

	tmr_state_t q;
	tmr_state_t d;

	// Next state; done and abort are one-cycle pulses
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.abort = 1'b0;
		case (q.st)
			T_IDLE:
			begin
				if (cv.start_fall)
				begin
					d.st = T_CONV;
					d.hold = 1'b1;
					d.rise_cnt = 4'h0;
					d.fall_cnt = 4'h0;
				end
			end
			T_CONV:
			begin
				// Early release of start kills the conversion
				if (cv.start_rise)
				begin
					d.st = T_IDLE;
					d.hold = 1'b0;
					d.abort = 1'b1;
				end
				else
				begin
					if (cv.cclk_rise)
					begin
						d.rise_cnt = q.rise_cnt + 4'h1;
						if (d.rise_cnt == `HOLD_RELEASE_RISE)
							d.hold = 1'b0;
					end
					if (cv.cclk_fall)
					begin
						d.fall_cnt = q.fall_cnt + 4'h1;
						if (d.fall_cnt == `CONV_DONE_FALL)
						begin
							d.st = T_IDLE;
							d.hold = 1'b0;
							d.done = 1'b1;
						end
					end
				end
			end
			default:
				d.st = T_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q.st <= T_IDLE;
			q.rise_cnt <= 4'h0;
			q.fall_cnt <= 4'h0;
			q.hold <= 1'b0;
			q.done <= 1'b0;
			q.abort <= 1'b0;
		end
		else
			q <= d;
	end

	// Outputs straight from the register
	assign cv.hold = q.hold;
	assign cv.done = q.done;
	assign cv.abort = q.abort;

endmodule : conv_timer

// >>> verification/sar_seq_monitor.sv
// Port assertions for the converter sequencer control
`timescale 1ns/1ps
module sar_seq_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	input wire logic conversion_start_n_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic word_byte_i,
	input wire logic [11:0] data_o,
	input wire logic data_oe_o,
	input wire logic busy_o,
	input wire logic track_o,
	input wire logic ref_internal_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Start taken only when tracking and idle
	sequence start_s;
		$fell(conversion_start_n_i) ##0 (track_o && !busy_o);
	endsequence
	sequence busy_s;
		$rose(busy_o);
	endsequence
	start_busy_a: assert property (start_s |-> ##[2:8] busy_o)
		else $error("busy missing after start");
	hold_on_a: assert property (busy_s |-> ##[0:1] !track_o)
		else $error("no hold at conversion start");
	busy_min_a: assert property (busy_s |-> busy_o [*8])
		else $error("busy too short");
	busy_end_a: assert property ($fell(busy_o) |-> ##[0:4] track_o)
		else $error("no tracking after busy end");
	bus_off_a: assert property ((cs_n_i || rd_n_i) [*6] |-> !data_oe_o)
		else $error("result bus driven while idle");
	byte_mode_a: assert property
		((!word_byte_i) [*6] ##0 data_oe_o |-> data_o[11:8] == 4'h0)
		else $error("byte mode upper bits set");
	ref_write_a: assert property
		($changed(ref_internal_o) |-> wb_ack_o || $past(wb_ack_o))
		else $error("reference changed without write");
	start_sync_a: assert property
		(busy_s |-> !$past(conversion_start_n_i, 3))
		else $error("busy ahead of synchronised start");
endmodule : sar_seq_monitor

// >>> verification/host_model.sv
// Host model driving start, conversion clock and read pins
`timescale 1ns/1ps
module host_model (
	input wire logic clk_i,
	output logic start_n_o,
	output logic cclk_o,
	output logic cs_n_o,
	output logic rd_n_o
);
	initial
	begin
		start_n_o = 1'b1;
		cclk_o = 1'b0;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_clk
	// Power-up pulse so the sampler starts tracking
	task automatic wake();
		start_n_o <= 1'b0;
		wait_clk(6);
		start_n_o <= 1'b1;
		wait_clk(2);
	endtask : wake
	// Clock stays low outside a frame; short bursts abort
	task automatic conv(input int falls, input int hold);
		wait_clk(30);
		start_n_o <= 1'b0;
		wait_clk(6);
		repeat (falls)
		begin
			cclk_o <= 1'b1;
			wait_clk(4);
			cclk_o <= 1'b0;
			wait_clk(4);
		end
		wait_clk(hold);
		start_n_o <= 1'b1;
		wait_clk(2);
	endtask : conv
	task automatic read();
		cs_n_o <= 1'b0;
		rd_n_o <= 1'b0;
		wait_clk(10);
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		wait_clk(8);
	endtask : read
endmodule : host_model

// >>> verification/sar_seq_ctrl_tb.sv
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module sar_seq_ctrl_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic conversion_start_n_i, conversion_clock_in_i, cs_n_i, rd_n_i;
	logic word_byte_i = 1'b1;
	logic high_byte_en_i = 1'b0;
	logic [11:0] sample_data_i = 12'h000;
	logic [11:0] data_o, smp;
	logic data_oe_o, busy_o, track_o, ref_internal_o, power_down_o;
	logic [2:0] mux_channel_o;
	logic [31:0] seed = 32'h00014b0a;
	logic [31:0] bus_q[$];
	logic [11:0] pin_q[$];
	int miscompares = 0;
	int num_checks = 0;
	int oe_cnt = 0;
	always #2.5 clk_i = ~clk_i;
	sar_seq_ctrl dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.conversion_start_n_i, .conversion_clock_in_i, .cs_n_i, .rd_n_i,
		.word_byte_i, .high_byte_en_i, .sample_data_i, .data_o,
		.data_oe_o, .busy_o, .track_o, .ref_internal_o, .power_down_o,
		.mux_channel_o);
	host_model host (.clk_i, .start_n_o(conversion_start_n_i),
		.cclk_o(conversion_clock_in_i), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	// Classic single cycle; held until ack, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// No cycle count assumed; only the watchdog ends a hang here
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// New sample each conversion, result fetched over the bus
	task automatic run(input logic [2:0] ch);
		smp = 12'(xs() >> 20);
		sample_data_i <= smp;
		chk(32'(mux_channel_o), 32'(ch));
		host.conv(14, 10);
		rd(8'h0c, {17'h0, ch, smp});
	endtask : run
	// Scoreboard: oldest note against each bus or pin result
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && !wb_we_i)
			chk(wb_dat_o, bus_q.pop_front());
		oe_cnt <= (data_oe_o === 1'b1) ? oe_cnt + 1 : 0;
		if (oe_cnt == 4)
			chk({20'h0, data_o}, {20'h0, pin_q.pop_front()});
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(track_o), 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0);
		host.wake();
		repeat (6) @(posedge clk_i);
		chk(32'(track_o), 32'h1);
		bus(1'b1, 8'h04, 32'h28);
		bus(1'b1, 8'h00, 32'h3a);
		chk(32'(ref_internal_o), 32'h1);
		for (int i = 0; i < 5; i++)
		begin
			if (i == 2)
				bus(1'b1, 8'h00, 32'h32);
			run(3'(i % 3));
		end
		// Word, low byte, high byte reads of the last result
		for (int m = 0; m < 3; m++)
		begin
			word_byte_i <= (m == 0);
			high_byte_en_i <= (m == 2);
			pin_q.push_back(m == 0 ? smp : m == 1 ? {4'h0, smp[7:0]} :
				{8'h0, smp[11:8]});
			repeat (6) @(posedge clk_i);
			host.read();
		end
		host.conv(5, 4);
		repeat (10) @(posedge clk_i);
		chk(32'(busy_o), 32'h0);
		chk(32'(track_o), 32'h1);
		rd(8'h0c, {17'h0, 3'h1, smp});
		bus(1'b1, 8'h00, 32'h05);
		chk(32'(ref_internal_o), 32'h0);
		run(3'h5);
		bus(1'b1, 8'h00, 32'h08);
		for (int i = 0; i < 3; i++)
			run(i == 1 ? 3'h5 : 3'h3);
		// Auto shutdown, then auto standby
		for (int p = 0; p < 2; p++)
		begin
			bus(1'b1, 8'h00, (p == 0) ? 32'h81 : 32'hc1);
			fork
				host.conv(14, 40);
				begin
					wait (busy_o === 1'b1);
					wait (busy_o === 1'b0);
					repeat (4) @(posedge clk_i);
					chk(32'(power_down_o), 32'h1);
				end
			join
			repeat (8) @(posedge clk_i);
			chk(32'(power_down_o), 32'h0);
			rd(8'h0c, {17'h0, 3'h1, smp});
		end
		end_of_test();
	end
	// Hang guard well beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end
endmodule : sar_seq_ctrl_tb
bind sar_seq_ctrl sar_seq_monitor u_mon (.clk_i, .rst_i, .wb_ack_o,
	.conversion_start_n_i, .cs_n_i, .rd_n_i, .word_byte_i, .data_o,
	.data_oe_o, .busy_o, .track_o, .ref_internal_o);
